// [include/ifp_pkg.sv]
package ifp_pkg;

    // Phase sequence inside one instruction cycle
    typedef enum logic [1:0] {
        PH_ONE   = 2'b00,
        PH_TWO   = 2'b01,
        PH_THREE = 2'b10,
        PH_FOUR  = 2'b11
    } ifp_phase_e;

    // Four phases per instruction cycle
    localparam int unsigned PHASES_PER_CYCLE = 4;

    // Program counter and instruction word layout
    localparam int unsigned PC_W        = 21;
    localparam int unsigned WORD_W      = 16;
    localparam int unsigned LIT_W       = 12;
    localparam int unsigned OFF_W_DFLT  = 11;
    localparam logic [PC_W-2:0] PC_RESET = 20'h0_0000;

    // Second-word marker in the top nibble
    localparam logic [3:0] SECOND_PFX = 4'hF;

    // First-word opcodes of the double-word instructions
    localparam logic [3:0] OPC_FILE_MOVE = 4'hC;
    localparam logic [7:0] OPC_JUMP_ABS  = 8'hEF;
    localparam logic [6:0] OPC_CALL_ABS  = 7'h76;
    localparam logic [7:0] OPC_PTR_LOAD  = 8'hEE;
    localparam logic [1:0] PTR_LOAD_SUB  = 2'h0;

    // Reset word value
    localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;

endpackage : ifp_pkg

// [rtl/ifp_fetch_pipe.sv]
`timescale 1ns/1ps

// Summary of operation
// - Input clock divided by four into phases
// - Cycle is phases one to four in order
// - Counter steps at phase one, fetch at four
// - Fetched word enters instruction register at one
// - Operand read phase two, result write four
// - Fetch overlaps execute, one instruction per cycle
// - Branch two cycles, skip two or three over a pair, absolute jump or call three, pairs two, others one
// - Prefetched word flushed as no-op on redirect
// - Byte addressed memory, words on even addresses
// - Counter steps by two, bit zero zero
// - Absolute target loads counter bits 20 to 1
// - Relative offset counted in two-byte words
// - Double-word second word: ones nibble, 12-bit literal
// - Lone ones-nibble word executes as no-op
module ifp_fetch_pipe #(
    parameter int unsigned OFF_W = ifp_pkg::OFF_W_DFLT
) (
    // Clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          srst_i,
    // Program memory
    output logic [ifp_pkg::PC_W-1:0]           pm_addr_o,
    input  wire logic [ifp_pkg::WORD_W-1:0]    pm_data_i,
    // Execute unit flow requests, sampled in phase four
    input  wire logic                          branch_i,
    input  wire logic [OFF_W-1:0]              branch_off_i,
    input  wire logic                          skip_i,
    // Execute side
    output logic [ifp_pkg::WORD_W-1:0]         ir_o,
    output logic                               exec_o,
    output logic                               operand_valid_o,
    output logic [ifp_pkg::LIT_W-1:0]          operand_o,
    output logic                               dm_rd_o,
    output logic                               dm_wr_o,
    // Phase clocks
    output logic                               phase_one_o,
    output logic                               phase_two_o,
    output logic                               phase_three_o,
    output logic                               phase_four_o
);
    import ifp_pkg::*;

    // Offset must fit inside the word counter
    if (OFF_W < 2 || OFF_W > PC_W - 1) begin : g_bad_off
        $error("branch offset width out of range");
    end

    typedef struct packed {
        logic [PC_W-2:0]   pcw;     // Word counter, bit zero implied
        logic              first;   // No step at the first phase one
        logic [WORD_W-1:0] fetch;   // Prefetched word
        logic              fvalid;
        logic [WORD_W-1:0] ir;
        logic [WORD_W-1:0] lead;    // First word of a pending pair
        logic              exec;
        logic              opnd;
        logic              two_pend;
        logic              flush;
        logic              redir;
        logic [PC_W-2:0]   tgt;
        logic              dm_rd;
        logic              dm_wr;
    } ifp_fp_s;

    ifp_fp_s    q, d;
    ifp_phase_e phase;
    logic       valid_w;

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // True for the first word of any double-word instruction
    function automatic logic is_pair_head(input logic [WORD_W-1:0] w);
        is_pair_head = (w[15:12] == OPC_FILE_MOVE) ||
                       (w[15:8] == OPC_JUMP_ABS) ||
                       (w[15:9] == OPC_CALL_ABS) ||
                       ((w[15:8] == OPC_PTR_LOAD) && (w[7:6] == PTR_LOAD_SUB));
    endfunction : is_pair_head

    // Absolute jump or call heads redirect on their second word
    function automatic logic is_abs_head(input logic [WORD_W-1:0] w);
        is_abs_head = (w[15:8] == OPC_JUMP_ABS) || (w[15:9] == OPC_CALL_ABS);
    endfunction : is_abs_head

    // Relative target: offset in words, so it adds directly to the word counter
    function automatic logic [PC_W-2:0] rel_target(input logic [PC_W-2:0] pcw,
                                                   input logic [OFF_W-1:0] off);
        logic [PC_W-2:0] ext;
        ext        = {{(PC_W-1-OFF_W){off[OFF_W-1]}}, off};
        rel_target = pcw + ext;
    endfunction : rel_target

    ////////////////////////////////////////////////////////////////////////////
    // Phase generator
    ifp_phase_gen u_phase (
        .clk_i         (clk_i),
        .srst_i        (srst_i),
        .phase_o       (phase),
        .phase_one_o   (phase_one_o),
        .phase_two_o   (phase_two_o),
        .phase_three_o (phase_three_o),
        .phase_four_o  (phase_four_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pipeline sequencing; each branch acts on the edge that closes its phase
    always_comb begin
        d       = q;
        valid_w = q.fvalid && !q.flush;
        case (phase)
            PH_ONE: begin
                // Counter steps here, or jumps to a pending target
                if (q.redir) begin
                    d.pcw = q.tgt;
                end else if (!q.first) begin
                    d.pcw = q.pcw + 20'h0_0001;
                end
                d.first = 1'b0;
                d.redir = 1'b0;
                d.flush = 1'b0;
                // Flushed word still loads but never executes
                d.ir    = q.fetch;
                d.opnd  = valid_w && q.two_pend && (q.fetch[15:12] == SECOND_PFX);
                d.exec  = valid_w && (q.fetch[15:12] != SECOND_PFX);
                d.two_pend = d.exec && is_pair_head(q.fetch);
                if (d.two_pend) begin
                    d.lead = q.fetch;
                end
                d.dm_rd = d.exec;
            end
            PH_TWO: begin
                d.dm_rd = 1'b0;
            end
            PH_THREE: begin
                d.dm_wr = q.exec;
            end
            PH_FOUR: begin
                d.dm_wr  = 1'b0;
                // Fetch overlaps the execution of the current word
                d.fetch  = pm_data_i;
                d.fvalid = 1'b1;
                if (q.opnd && is_abs_head(q.lead)) begin
                    d.redir = 1'b1;
                    d.flush = 1'b1;
                    d.tgt   = {q.ir[LIT_W-1:0], q.lead[7:0]};
                end else if (q.exec && !q.two_pend && branch_i) begin
                    d.redir = 1'b1;
                    d.flush = 1'b1;
                    d.tgt   = rel_target(q.pcw, branch_off_i);
                end else if (q.exec && !q.two_pend && skip_i) begin
                    // Skipped word drops out; a lone second word then runs as no-op
                    d.flush = 1'b1;
                end
            end
            default: begin
                d = q;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; pipeline empty after reset
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            q.pcw      <= PC_RESET;
            q.first    <= 1'b1;
            q.fetch    <= WORD_ZERO;
            q.fvalid   <= 1'b0;
            q.ir       <= WORD_ZERO;
            q.lead     <= WORD_ZERO;
            q.exec     <= 1'b0;
            q.opnd     <= 1'b0;
            q.two_pend <= 1'b0;
            q.flush    <= 1'b0;
            q.redir    <= 1'b0;
            q.tgt      <= PC_RESET;
            q.dm_rd    <= 1'b0;
            q.dm_wr    <= 1'b0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs; byte address with bit zero forced low
    assign pm_addr_o       = {q.pcw, 1'b0};
    assign ir_o            = q.ir;
    assign exec_o          = q.exec;
    assign operand_valid_o = q.opnd;
    assign operand_o       = q.ir[LIT_W-1:0];
    assign dm_rd_o         = q.dm_rd;
    assign dm_wr_o         = q.dm_wr;

endmodule : ifp_fetch_pipe

// [rtl/ifp_phase_gen.sv]
`timescale 1ns/1ps

// Divides the input clock by four into non-overlapping phases
module ifp_phase_gen (
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                srst_i,
    // Phase outputs
    output ifp_pkg::ifp_phase_e      phase_o,
    output logic                     phase_one_o,
    output logic                     phase_two_o,
    output logic                     phase_three_o,
    output logic                     phase_four_o
);
    import ifp_pkg::*;

    typedef struct packed {
        ifp_phase_e ph;
        logic [3:0] hot;
    } ifp_pg_s;

    ifp_pg_s q, d;

    ////////////////////////////////////////////////////////////////////////////
    // Next phase; one-hot kept in step so no output has gates after it
    always_comb begin
        d = q;
        case (q.ph)
            PH_ONE: begin
                d.ph = PH_TWO;
            end
            PH_TWO: begin
                d.ph = PH_THREE;
            end
            PH_THREE: begin
                d.ph = PH_FOUR;
            end
            PH_FOUR: begin
                d.ph = PH_ONE;
            end
            default: begin
                d.ph = PH_ONE;
            end
        endcase
        d.hot = 4'h1 << d.ph;
    end

    // Start at phase one after reset
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            q.ph  <= PH_ONE;
            q.hot <= 4'h1;
        end else begin
            q <= d;
        end
    end

    assign phase_o       = q.ph;
    assign phase_one_o   = q.hot[0];
    assign phase_two_o   = q.hot[1];
    assign phase_three_o = q.hot[2];
    assign phase_four_o  = q.hot[3];

endmodule : ifp_phase_gen

// [tb/ifp_fetch_pipe_props.sv]
`timescale 1ns/1ps

// Phase, pipeline and flush timing seen at the top ports
module ifp_fetch_pipe_props (
    // Clock and reset
    input wire logic                       clk_i,
    input wire logic                       srst_i,
    // Watched ports
    input wire logic [ifp_pkg::PC_W-1:0]   pm_addr_o,
    input wire logic                       branch_i,
    input wire logic [ifp_pkg::WORD_W-1:0] ir_o,
    input wire logic                       exec_o,
    input wire logic                       operand_valid_o,
    input wire logic [ifp_pkg::LIT_W-1:0]  operand_o,
    input wire logic                       dm_rd_o,
    input wire logic                       dm_wr_o,
    input wire logic                       phase_one_o,
    input wire logic                       phase_two_o,
    input wire logic                       phase_three_o,
    input wire logic                       phase_four_o
);
    import ifp_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // Phase one lasts one sample after reset as in any cycle; start only once running
    sequence rest_s;
        phase_two_o ##1 phase_three_o ##1 phase_four_o ##1 phase_one_o;
    endsequence
    phase_order_a: assert property (phase_one_o && !$past(srst_i) |=> rest_s)
        else $error("phase order broken");
    one_hot_a: assert property ($onehot({phase_one_o, phase_two_o, phase_three_o, phase_four_o}))
        else $error("phases not one-hot");
    addr_hold_a: assert property (!phase_one_o |=> $stable(pm_addr_o))
        else $error("address moved off phase one");
    pc_align_a: assert property (pm_addr_o[0] == 1'b0)
        else $error("odd fetch address");
    ir_hold_a: assert property (!phase_one_o |=> $stable(ir_o) && $stable(exec_o))
        else $error("instruction moved mid cycle");
    dm_read_a: assert property (dm_rd_o == (phase_two_o && exec_o))
        else $error("operand read strobe wrong");
    dm_write_a: assert property (dm_wr_o == (phase_four_o && exec_o))
        else $error("result write strobe wrong");
    flush_nop_a: assert property (phase_four_o && exec_o && branch_i && ir_o[15:12] < 4'hC
        |-> ##2 !exec_o [*4])
        else $error("prefetched word not flushed");
    lone_second_a: assert property (ir_o[15:12] == SECOND_PFX |-> !exec_o)
        else $error("second word executed");
    operand_word_a: assert property (operand_valid_o
        |-> operand_o == ir_o[11:0] && ir_o[15:12] == SECOND_PFX)
        else $error("operand literal wrong");
    reset_state_a: assert property (disable iff (1'b0)
        srst_i |=> phase_one_o && pm_addr_o == '0 && !exec_o)
        else $error("reset state wrong");
endmodule : ifp_fetch_pipe_props

bind ifp_fetch_pipe ifp_fetch_pipe_props i_ifp_fetch_pipe_props (
    .clk_i(clk_i), .srst_i(srst_i), .pm_addr_o(pm_addr_o), .branch_i(branch_i),
    .ir_o(ir_o), .exec_o(exec_o), .operand_valid_o(operand_valid_o),
    .operand_o(operand_o), .dm_rd_o(dm_rd_o), .dm_wr_o(dm_wr_o),
    .phase_one_o(phase_one_o), .phase_two_o(phase_two_o),
    .phase_three_o(phase_three_o), .phase_four_o(phase_four_o));

// [tb/ifp_prog_mem.sv]
`timescale 1ns/1ps

// Program memory stand-in: 64 words, mirrored over the address space
module ifp_prog_mem (
    // Fetch side
    input  wire logic [ifp_pkg::PC_W-1:0] addr_i,
    output logic [ifp_pkg::WORD_W-1:0]    data_o
);
    import ifp_pkg::*;
    logic [WORD_W-1:0] mem [64];
    // Byte address; the word sits at the even byte
    assign data_o = mem[addr_i[6:1]];
endmodule : ifp_prog_mem

// [tb/instruction_fetch_pipeline_test.sv]
`timescale 1ns/1ps

// Random program walk checked against a reference of the pipeline
module instruction_fetch_pipeline_test;
    import ifp_pkg::*;
    localparam int OW = 11;
    localparam int N = 150;
    logic              clk_i = 1'b0;
    logic              srst_i = 1'b1;
    logic              branch_i = 1'b0;
    logic              skip_i = 1'b0;
    logic [OW-1:0]     branch_off_i = '0;
    logic [PC_W-1:0]   pm_addr_o;
    logic [WORD_W-1:0] pm_data_i;
    logic [WORD_W-1:0] ir_o;
    logic [LIT_W-1:0]  operand_o;
    logic              exec_o, operand_valid_o, ph1, ph2;
    logic [38:0]       q[$];
    logic [38:0]       x;
    logic              br_a [N];
    logic              sk_a [N];
    logic [OW-1:0]     of_a [N];
    int                num_errors = 0;
    int                cmp_count = 0;

    ifp_fetch_pipe #(.OFF_W(OW)) i_ifp_fetch_pipe (
        .clk_i(clk_i), .srst_i(srst_i), .pm_addr_o(pm_addr_o), .pm_data_i(pm_data_i),
        .branch_i(branch_i), .branch_off_i(branch_off_i), .skip_i(skip_i), .ir_o(ir_o),
        .exec_o(exec_o), .operand_valid_o(operand_valid_o), .operand_o(operand_o),
        .dm_rd_o(), .dm_wr_o(), .phase_one_o(ph1), .phase_two_o(ph2),
        .phase_three_o(), .phase_four_o());
    ifp_prog_mem i_ifp_prog_mem (.addr_i(pm_addr_o), .data_o(pm_data_i));

    always #25 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////
    function automatic logic is_head(logic [WORD_W-1:0] w);
        return w[15:12] == OPC_FILE_MOVE || w[15:8] == OPC_JUMP_ABS || w[15:9] == OPC_CALL_ABS
            || (w[15:8] == OPC_PTR_LOAD && w[7:6] == PTR_LOAD_SUB);
    endfunction : is_head

    // Reset mid-run, build the expected walk, then drive flow requests
    task automatic run_pass(input int p);
        logic [PC_W-1:0]   e, tgt, nt;
        logic [WORD_W-1:0] w, hw;
        logic              fl, hp, ex, ov, hd, rd;
        e = '0;
        tgt = '0;
        hw = '0;
        {fl, hp} = 2'b00;
        @(posedge clk_i) srst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        for (int k = 0; k < N; k++) begin
            br_a[k] = ($urandom % 8) == 0;
            sk_a[k] = ($urandom % 8) == 0;
            of_a[k] = OW'($signed(4'($urandom)));
        end
        q.push_back({WORD_ZERO, 2'b00, 21'h00_0000});
        for (int k = 1; k < N; k++) begin
            w = i_ifp_prog_mem.mem[e[6:1]];
            ov = !fl && hp && w[15:12] == SECOND_PFX;
            ex = !fl && w[15:12] != SECOND_PFX;
            hd = ex && is_head(w);
            rd = 1'b1;
            if (ex && !hd && br_a[k])
                nt = e + 21'd2 + {{(PC_W-OW-1){of_a[k][OW-1]}}, of_a[k], 1'b0};
            else if (ov && (hw[15:8] == OPC_JUMP_ABS || hw[15:9] == OPC_CALL_ABS))
                nt = {w[11:0], hw[7:0], 1'b0};
            else if (ex && !hd && sk_a[k])
                nt = e + 21'd4;
            else
                rd = 1'b0;
            // A redirect reaches the counter at the flushed cycle's phase one
            q.push_back({w, ex, ov, fl ? tgt : e + 21'd2});
            e = fl ? tgt : e + 21'd2;
            tgt = nt;
            fl = rd;
            hp = hd;
            hw = w;
        end
        srst_i <= 1'b0;
        @(posedge clk_i);
        // Request k is driven as phase one of cycle k ends and sampled at its phase four
        for (int k = 1; k < N; k++) begin
            @(negedge clk_i);
            while (!ph1) @(negedge clk_i);
            @(posedge clk_i);
            branch_i <= br_a[k];
            skip_i <= sk_a[k];
            branch_off_i <= of_a[k];
        end
        repeat (6) @(posedge clk_i);
        if (q.size() != 0) begin
            num_errors++;
            $display("wrong value at %0t: results missing", $time);
        end
        $display("pass %0d done, compares so far %0d", p, cmp_count);
    endtask : run_pass

    // Each phase two of a cycle settles one expected result
    always @(negedge clk_i) begin
        if (!srst_i && ph2 && q.size() > 0) begin
            x = q.pop_front();
            cmp_count += 3;
            if ({exec_o, operand_valid_o} !== x[22:21]) begin
                num_errors++;
                $display("wrong value at %0t: exec flags", $time);
            end
            if ({ir_o, pm_addr_o} !== {x[38:23], x[20:0]}) begin
                num_errors++;
                $display("wrong value at %0t: word or address", $time);
            end
            if (x[21] && operand_o !== x[34:23]) begin
                num_errors++;
                $display("wrong value at %0t: operand", $time);
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    task automatic results();
        $display("compares %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results

    // Hang guard: about three times the expected run
    initial begin
        #200_000;
        num_errors++;
        $display("wrong value at %0t: timeout", $time);
        results();
    end

    // Random words without markers, then pairs, a lone marker and jumps
    initial begin
        void'($urandom(32'h3a8a4144));
        for (int i = 0; i < 64; i++)
            i_ifp_prog_mem.mem[i] = {4'($urandom_range(11)), 12'($urandom)};
        i_ifp_prog_mem.mem[10] = 16'hC123;
        i_ifp_prog_mem.mem[11] = 16'hF456;
        i_ifp_prog_mem.mem[20] = 16'hEE12;
        i_ifp_prog_mem.mem[21] = 16'hF789;
        i_ifp_prog_mem.mem[25] = 16'hF0AA;
        i_ifp_prog_mem.mem[40] = 16'hEC2C;
        i_ifp_prog_mem.mem[41] = 16'hF000;
        i_ifp_prog_mem.mem[50] = 16'hEF00;
        i_ifp_prog_mem.mem[51] = 16'hF000;
        run_pass(1);
        run_pass(2);
        results();
    end
endmodule : instruction_fetch_pipeline_test
